// *** logic/g2h_defines.svh ***
// Register map, field positions, reset values and timing of the group 2 handshake port.
// Assumes a 20 MHz clock and an APB slave with an 8-bit word-aligned address.
`ifndef G2H_DEFINES_SVH
`define G2H_DEFINES_SVH

// Register byte offsets
`define G2H_OFS_CONFIG 8'h00
`define G2H_OFS_DATA 8'h04
`define G2H_OFS_DIR 8'h08
`define G2H_OFS_STATUS 8'h0c

// Configuration register fields
`define G2H_BIT_PORTD_HS_EN 10
`define G2H_BIT_PORTC_HS_EN 9
`define G2H_BIT_LOCAL_RESET 8
`define G2H_BIT_REQ_INVERT 6
`define G2H_BIT_PORTC_DBL 5
`define G2H_BIT_PULSE_MODE 4
`define G2H_BIT_TRAILING 3
`define G2H_BIT_ACK_INVERT 2
`define G2H_BIT_ACK_MANUAL 1
`define G2H_BIT_EXTRA_OUT 0

// Direction register fields
`define G2H_BIT_PORTC_WRITE 0
`define G2H_BIT_PORTD_WRITE 1

// Status register fields
`define G2H_BIT_ST_DATA_READY 0
`define G2H_BIT_ST_ACK 1
`define G2H_BIT_ST_REQ_ACTIVE 2
`define G2H_BIT_ST_LOCAL_RESET 3
`define G2H_BIT_ST_BUSY 4

// Reset values
`define G2H_RST_PORT_DATA 8'h00

// Timing
`define G2H_CLK_MHZ 20
`define G2H_ACK_PULSE_NS 100

`endif

// *** logic/g2h_pkg.sv ***
// Types shared by the group 2 handshake port design.
// Assumes g2h_defines.svh carries every number.
package g2h_pkg;

	typedef enum logic [1:0] {
		G2H_IDLE,
		G2H_XFER,
		G2H_ACK
	} g2h_hs_t;

	typedef struct packed {
		logic portd_en;
		logic portc_en;
		logic local_reset;
		logic req_invert;
		logic portc_dbl;
		logic pulse_mode;
		logic trailing;
		logic ack_invert;
		logic ack_manual;
		logic extra_out;
	} g2h_cfg_t;

	typedef struct packed {
		g2h_cfg_t cfg;
		logic portc_write;
		logic portd_write;
		logic [7:0] portc_first;
		logic [7:0] portc_second;
		logic [7:0] portd_data;
		g2h_hs_t hs;
		logic [3:0] ack_cnt;
		logic req_prev;
		logic [15:0] xfer_word;
		logic push_valid;
		logic [7:0] portc_pin;
		logic portc_pin_oe;
		logic [7:0] portd_pin;
		logic portd_pin_oe;
		logic ack_pin;
		logic extra_pin;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} g2h_state_t;

endpackage : g2h_pkg

// *** logic/g2h_sync.sv ***
// Three-stage input synchroniser with agreement filter for connector pins.
// Assumes inputs are asynchronous to clk; output changes only when stages two and three agree.
module g2h_sync
	import g2h_pkg::*;
#(
	parameter int W = 8
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pin side
	input wire logic [W-1:0] din,
	// Synchronised side
	output logic [W-1:0] dout
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} g2h_sync_state_t;

	g2h_sync_state_t st;
	g2h_sync_state_t next_st;

	always_comb
	begin
		next_st = st;
		next_st.s1 = din;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < W; i++)
		begin
			if (st.s2[i] == st.s3[i])
				next_st.q[i] = st.s3[i];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign dout = st.q;

endmodule : g2h_sync

// *** logic/g2h_buf.sv ***
// Two-entry buffer with valid/ready on both sides and a flush input.
// Assumes single clock; read data come from the storage registers.
module g2h_buf
	import g2h_pkg::*;
#(
	parameter int W = 16
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);

	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic wr_ptr;
		logic rd_ptr;
		logic [1:0] count;
	} g2h_buf_state_t;

	g2h_buf_state_t st;
	g2h_buf_state_t next_st;
	logic push;
	logic pop;

	assign in_ready = (st.count != 2'h2);
	assign out_valid = (st.count != 2'h0);
	assign out_data = st.mem[st.rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb
	begin
		next_st = st;
		if (flush)
		begin
			next_st.count = 2'h0;
			next_st.wr_ptr = 1'b0;
			next_st.rd_ptr = 1'b0;
		end
		else
		begin
			if (push)
			begin
				next_st.mem[st.wr_ptr] = in_data;
				next_st.wr_ptr = ~st.wr_ptr;
			end
			if (pop)
				next_st.rd_ptr = ~st.rd_ptr;
			if (push && !pop)
				next_st.count = st.count + 2'h1;
			else if (pop && !push)
				next_st.count = st.count - 2'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

endmodule : g2h_buf

// *** logic/g2h_port.sv ***
// Group 2 handshake port: ports C and D of a parallel digital I/O group with APB registers.
// Assumes an APB3 master on clk; connector pins are asynchronous and pass a synchroniser.
//
// Operation
// - Port D handshake enable makes port D join the group 2 handshake.
// - Port C handshake enable makes port C join the group 2 handshake.
// - Setting then clearing local reset returns group 2 handshake logic to reset.
// - Configuration bit 7 is ignored.
// - Request invert selects low-active request; otherwise request is high-active.
// - Double-buffered output: host fills first buffer, request moves it to connector buffer.
// - Single-buffered output: host write appears on the connector at once.
// - Double-buffered input: request latches connector data; reads return latched data.
// - Single-buffered input: reads return live connector data.
// - Pulse mode makes request and acknowledge pulses, else levels.
// - In pulse mode act on trailing edge if selected, else leading edge.
// - Acknowledge invert set: acknowledge driven low to end a transfer.
// - Acknowledge invert clear: acknowledge driven high to end a transfer.
// - Manual acknowledge bit drives the acknowledge line directly.
// - Extra output bit drives the spare output line directly.
`include "g2h_defines.svh"

module g2h_port
	import g2h_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int PORT_W = 8
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Port C connector pins
	input wire logic [PORT_W-1:0] portc_in,
	output logic [PORT_W-1:0] portc_out,
	output logic portc_oe,
	// Port D connector pins
	input wire logic [PORT_W-1:0] portd_in,
	output logic [PORT_W-1:0] portd_out,
	output logic portd_oe,
	// Handshake and spare lines
	input wire logic group2_request,
	output logic group2_acknowledge,
	output logic extra_output_two
);

	localparam int ACK_PULSE_CYC = (`G2H_ACK_PULSE_NS * `G2H_CLK_MHZ + 999) / 1000;
	localparam logic [3:0] ACK_PULSE_LAST = 4'(ACK_PULSE_CYC - 1);

	logic rst_q1;
	logic rst_n;
	g2h_state_t st;
	g2h_state_t next_st;
	logic [PORT_W-1:0] portc_sync;
	logic [PORT_W-1:0] portd_sync;
	logic req_sync;
	logic buf_in_ready;
	logic buf_out_valid;
	logic [15:0] buf_out_data;
	logic buf_pop;
	logic buf_flush;
	logic setup;
	logic access_done;
	logic req_act;
	logic hs_event;
	logic latch_mode;

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end

	g2h_sync #(
		.W(PORT_W)
	) u_sync_c (
		.clk(clk),
		.rst_n(rst_n),
		.din(portc_in),
		.dout(portc_sync)
	);

	g2h_sync #(
		.W(PORT_W)
	) u_sync_d (
		.clk(clk),
		.rst_n(rst_n),
		.din(portd_in),
		.dout(portd_sync)
	);

	g2h_sync #(
		.W(1)
	) u_sync_req (
		.clk(clk),
		.rst_n(rst_n),
		.din(group2_request),
		.dout(req_sync)
	);

	// Latched input words wait here so a slow reader does not lose a transfer
	g2h_buf #(
		.W(16)
	) u_buf (
		.clk(clk),
		.rst_n(rst_n),
		.flush(buf_flush),
		.in_valid(st.push_valid),
		.in_ready(buf_in_ready),
		.in_data(st.xfer_word),
		.out_valid(buf_out_valid),
		.out_ready(buf_pop),
		.out_data(buf_out_data)
	);

	function automatic logic active_level(input logic raw, input logic invert);
		active_level = raw ^ invert;
	endfunction : active_level

	function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
		is_reg = (a == ADDR_W'(ofs));
	endfunction : is_reg

	function automatic logic group_enabled(input g2h_cfg_t c);
		group_enabled = (c.portc_en || c.portd_en) && !c.local_reset;
	endfunction : group_enabled

	assign setup = psel && !penable;
	assign access_done = psel && penable && st.pready;
	assign req_act = active_level(req_sync, st.cfg.req_invert);
	assign latch_mode = (st.cfg.portc_en && !st.portc_write && st.cfg.portc_dbl) ||
		(st.cfg.portd_en && !st.portd_write);
	assign buf_pop = access_done && !pwrite && is_reg(paddr, `G2H_OFS_DATA) &&
		latch_mode && buf_out_valid;
	assign buf_flush = st.cfg.local_reset;

	// Pulse mode picks leading or trailing edge; level mode acts as the request goes active
	always_comb
	begin
		if (st.cfg.pulse_mode && st.cfg.trailing)
			hs_event = !req_act && st.req_prev;
		else
			hs_event = req_act && !st.req_prev;
	end

	always_comb
	begin
		next_st = st;
		next_st.pready = setup;
		next_st.pslverr = 1'b0;
		next_st.prdata = 32'h0;

		// Register read data and unmapped answer are prepared in the setup cycle
		if (setup)
		begin
			if (!pwrite)
			begin
				if (is_reg(paddr, `G2H_OFS_DATA))
				begin
					if (latch_mode && buf_out_valid)
						next_st.prdata[15:0] = buf_out_data;
					else
						next_st.prdata[15:0] = {portd_sync, portc_sync};
					if (!(st.cfg.portd_en && !st.portd_write))
						next_st.prdata[15:8] = portd_sync;
					if (!(st.cfg.portc_en && !st.portc_write && st.cfg.portc_dbl))
						next_st.prdata[7:0] = portc_sync;
				end
				else if (is_reg(paddr, `G2H_OFS_DIR))
				begin
					next_st.prdata[`G2H_BIT_PORTC_WRITE] = st.portc_write;
					next_st.prdata[`G2H_BIT_PORTD_WRITE] = st.portd_write;
				end
				else if (is_reg(paddr, `G2H_OFS_STATUS))
				begin
					next_st.prdata[`G2H_BIT_ST_DATA_READY] = buf_out_valid;
					next_st.prdata[`G2H_BIT_ST_ACK] = (st.hs == G2H_ACK);
					next_st.prdata[`G2H_BIT_ST_REQ_ACTIVE] = req_act;
					next_st.prdata[`G2H_BIT_ST_LOCAL_RESET] = st.cfg.local_reset;
					next_st.prdata[`G2H_BIT_ST_BUSY] = (st.hs != G2H_IDLE);
				end
				else if (!is_reg(paddr, `G2H_OFS_CONFIG))
					next_st.pslverr = 1'b1;
			end
			else if (!is_reg(paddr, `G2H_OFS_CONFIG) && !is_reg(paddr, `G2H_OFS_DATA) &&
				!is_reg(paddr, `G2H_OFS_DIR))
				next_st.pslverr = 1'b1;
		end

		// Register writes take effect at the completing access edge
		if (access_done && pwrite)
		begin
			if (is_reg(paddr, `G2H_OFS_CONFIG))
			begin
				if (st.cfg.local_reset && !pwdata[`G2H_BIT_LOCAL_RESET])
					next_st.cfg = '0;
				else
				begin
					next_st.cfg.portd_en = pwdata[`G2H_BIT_PORTD_HS_EN];
					next_st.cfg.portc_en = pwdata[`G2H_BIT_PORTC_HS_EN];
					next_st.cfg.local_reset = pwdata[`G2H_BIT_LOCAL_RESET];
					next_st.cfg.req_invert = pwdata[`G2H_BIT_REQ_INVERT];
					next_st.cfg.portc_dbl = pwdata[`G2H_BIT_PORTC_DBL];
					next_st.cfg.pulse_mode = pwdata[`G2H_BIT_PULSE_MODE];
					next_st.cfg.trailing = pwdata[`G2H_BIT_TRAILING];
					next_st.cfg.ack_invert = pwdata[`G2H_BIT_ACK_INVERT];
					next_st.cfg.ack_manual = pwdata[`G2H_BIT_ACK_MANUAL];
					next_st.cfg.extra_out = pwdata[`G2H_BIT_EXTRA_OUT];
					// Bit 7 has no storage and is dropped
				end
			end
			else if (is_reg(paddr, `G2H_OFS_DATA))
			begin
				next_st.portc_first = pwdata[7:0];
				next_st.portd_data = pwdata[15:8];
			end
			else if (is_reg(paddr, `G2H_OFS_DIR))
			begin
				next_st.portc_write = pwdata[`G2H_BIT_PORTC_WRITE];
				next_st.portd_write = pwdata[`G2H_BIT_PORTD_WRITE];
			end
		end

		// Handshake sequencer
		unique case (st.hs)
			G2H_IDLE:
			begin
				if (hs_event && group_enabled(st.cfg))
				begin
					if (st.cfg.portc_en && st.portc_write && st.cfg.portc_dbl)
						next_st.portc_second = st.portc_first;
					next_st.ack_cnt = 4'h0;
					if (latch_mode)
					begin
						next_st.xfer_word = {portd_sync, portc_sync};
						next_st.push_valid = 1'b1;
						next_st.hs = G2H_XFER;
					end
					else
						next_st.hs = G2H_ACK;
				end
			end
			G2H_XFER:
			begin
				// A full buffer holds off the acknowledge, stalling the far end
				if (buf_in_ready)
				begin
					next_st.push_valid = 1'b0;
					next_st.hs = G2H_ACK;
				end
			end
			G2H_ACK:
			begin
				if (st.cfg.pulse_mode)
				begin
					next_st.ack_cnt = st.ack_cnt + 4'h1;
					if (st.ack_cnt == ACK_PULSE_LAST)
						next_st.hs = G2H_IDLE;
				end
				else if (!req_act)
					next_st.hs = G2H_IDLE;
			end
		endcase

		// Local reset holds the handshake idle and drops any latched word
		if (next_st.cfg.local_reset || st.cfg.local_reset)
		begin
			next_st.hs = G2H_IDLE;
			next_st.push_valid = 1'b0;
			next_st.ack_cnt = 4'h0;
		end

		// Track with the polarity now written, so a polarity change makes no false edge
		next_st.req_prev = active_level(req_sync, next_st.cfg.req_invert);

		// Connector pins follow the next state so each comes from a flop
		if (next_st.cfg.portc_dbl && next_st.portc_write)
			next_st.portc_pin = next_st.portc_second;
		else
			next_st.portc_pin = next_st.portc_first;
		next_st.portc_pin_oe = next_st.portc_write;
		next_st.portd_pin = next_st.portd_data;
		next_st.portd_pin_oe = next_st.portd_write;
		if (next_st.hs == G2H_ACK)
			next_st.ack_pin = !next_st.cfg.ack_invert;
		else
			next_st.ack_pin = next_st.cfg.ack_manual;
		next_st.extra_pin = next_st.cfg.extra_out;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.hs <= G2H_IDLE;
			st.portc_first <= `G2H_RST_PORT_DATA;
			st.portc_second <= `G2H_RST_PORT_DATA;
			st.portd_data <= `G2H_RST_PORT_DATA;
		end
		else
			st <= next_st;
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign portc_out = st.portc_pin;
	assign portc_oe = st.portc_pin_oe;
	assign portd_out = st.portd_pin;
	assign portd_oe = st.portd_pin_oe;
	assign group2_acknowledge = st.ack_pin;
	assign extra_output_two = st.extra_pin;

endmodule : g2h_port

// *** tb/g2h_port_sva.sv ***
// Checker for g2h_port: APB answers, static lines and acknowledge timing.
// Assumes default widths; cfg_q mirrors the last configuration write.
module g2h_port_sva
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Connector
	input wire logic [7:0] portc_out,
	input wire logic portc_oe,
	input wire logic group2_request,
	input wire logic group2_acknowledge,
	input wire logic extra_output_two
);
	logic [10:0] cfg_q;
	logic wr;
	logic on;
	logic lvl;
	assign wr = psel && penable && pready && pwrite && !pslverr;
	assign on = group2_acknowledge == !cfg_q[2];
	// Only where idle and active acknowledge levels differ
	assign lvl = !cfg_q[8] && cfg_q[1] == cfg_q[2];
	// Clearing local reset wipes the whole configuration
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			cfg_q <= 11'h000;
		else if (wr && paddr == 8'h00)
			cfg_q <= (cfg_q[8] && !pwdata[8]) ? 11'h000 : pwdata[10:0];
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);
	chk_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not one cycle");
	chk_unmapped_err: assert property (
		psel && !penable && paddr > 8'h0c |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	chk_config_wo: assert property (
		psel && !penable && !pwrite && paddr == 8'h00 |=> prdata == 32'h0)
		else $error("config read not zero");
	chk_extra_line: assert property (
		wr && paddr == 8'h00 |=> extra_output_two == cfg_q[0])
		else $error("extra line wrong");
	chk_reset_idle_ack: assert property (
		cfg_q[8] && $past(cfg_q[8]) |-> group2_acknowledge == cfg_q[1])
		else $error("ack not idle in local reset");
	chk_single_buf: assert property (
		wr && paddr == 8'h04 && portc_oe && !cfg_q[5] |=> portc_out == $past(pwdata[7:0]))
		else $error("single buffer not immediate");
	chk_double_buf: assert property (
		wr && paddr == 8'h04 && portc_oe && cfg_q[5] |=> $stable(portc_out))
		else $error("double buffer leaked");
	chk_ack_pulse: assert property (
		cfg_q[4] && lvl && $rose(on) && !$past(wr) |-> on ##1 on ##1 !on)
		else $error("ack pulse not two cycles");
	chk_ack_level: assert property (
		!cfg_q[4] && lvl && on && group2_request != cfg_q[6] && !wr |=> on)
		else $error("ack level dropped early");
	chk_ack_cause: assert property (
		!cfg_q[4] && lvl && $rose(on) && !$past(wr)
		|-> cfg_q[10:9] != 2'b00 && $past(group2_request, 3) != cfg_q[6])
		else $error("ack without request");
	cov_pulse: cover property (cfg_q[4] && $rose(on));
	cov_data_wr: cover property (wr && paddr == 8'h04);
	cov_refused: cover property (pslverr);
endmodule : g2h_port_sva

bind g2h_port g2h_port_sva u_sva
(
	.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.portc_out, .portc_oe, .group2_request, .group2_acknowledge, .extra_output_two
);

// *** tb/g2h_far.sv ***
// Far-side equipment: presents port data, raises the request, watches the acknowledge.
// Assumes the bench sets the polarities while handshaking is disabled.
module g2h_far
(
	// Clock
	input wire logic clk,
	// Connector lines
	input wire logic ack,
	output logic req,
	output logic [7:0] pc,
	output logic [7:0] pd
);
	timeunit 1ns;
	timeprecision 1ns;
	logic act = 1'b0;
	logic rinv = 1'b0;
	logic ainv = 1'b0;
	assign req = act ^ rinv;
	initial
		{pd, pc} = 16'h0000;
	// Data change mid-pulse so leading and trailing capture differ
	task automatic send(input logic pulse, input logic [15:0] a, input logic [15:0] b,
		output logic ok);
		ok = 1'b0;
		{pd, pc} <= a;
		repeat (8) @(posedge clk);
		act <= 1'b1;
		for (int i = 0; i < 80 && !(ok && (!pulse || i > 12)); i++)
		begin
			@(posedge clk);
			if (pulse && i == 4)
				{pd, pc} <= b;
			if (pulse && i == 8)
				act <= 1'b0;
			if (ack === !ainv)
				ok = 1'b1;
		end
		// A level request is held until acknowledged
		act <= 1'b0;
		// Hold time over: lines no longer show the word
		{pd, pc} <= ~b;
		@(posedge clk);
	endtask : send
endmodule : g2h_far

// *** tb/test_g2h_port.sv ***
// Bench for the group 2 handshake port: APB host, far-side model, verdict.
// Assumes g2h_port with default widths and the model g2h_far.
module test_g2h_port;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] pc;
	logic [7:0] pd;
	logic [7:0] portc_out;
	logic portc_oe;
	logic [7:0] pdo;
	logic pdoe;
	logic req;
	logic ack;
	logic extra;
	logic [31:0] rdat;
	logic rerr;
	int errors = 0;
	int checks = 0;
	initial
		forever #25 clk = ~clk;
	g2h_port u_dut
	(
		.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.portc_in(pc), .portc_out(portc_out), .portc_oe(portc_oe), .portd_in(pd),
		.portd_out(pdo), .portd_oe(pdoe), .group2_request(req), .group2_acknowledge(ack),
		.extra_output_two(extra)
	);
	g2h_far u_far
	(
		.clk(clk), .ack(ack), .req(req), .pc(pc), .pd(pd)
	);
	task automatic results();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1);
		// The slave answers in the cycle right after setup
		chk(64'(n), 64'h1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	function automatic logic [15:0] expw(input logic p, input logic t, input logic [15:0] a,
		input logic [15:0] b);
		return (p && t) ? b : a;
	endfunction : expw
	initial
	begin
		logic [31:0] r;
		logic [15:0] a;
		logic [15:0] b;
		logic ok;
		logic pl;
		logic tr;
		r = $urandom(98);
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		chk({ack, extra, portc_oe, pdoe}, 4'h0);
		apb(1'b0, 8'h00, 32'h0);
		chk(rdat, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk(rerr, 1'b1);
		repeat (4)
		begin
			r = $urandom & 32'h0000_0083;
			apb(1'b1, 8'h00, r);
			chk({ack, extra}, r[1:0]);
		end
		apb(1'b1, 8'h08, 32'h3);
		a = $urandom;
		apb(1'b1, 8'h04, {16'h0, a});
		chk({pdoe, pdo, portc_out}, {1'b1, a});
		apb(1'b1, 8'h00, 32'h0220);
		b = $urandom;
		apb(1'b1, 8'h04, {16'h0, b});
		// Second buffer still holds its reset value; port D is single buffered
		chk({pdo, portc_out}, {b[15:8], 8'h00});
		u_far.send(1'b0, a, a, ok);
		chk({ok, portc_out}, {1'b1, b[7:0]});
		apb(1'b1, 8'h08, 32'h0);
		apb(1'b1, 8'h00, 32'h0620);
		a = $urandom;
		b = $urandom;
		r = $urandom;
		u_far.send(1'b0, a, a, ok);
		u_far.send(1'b0, b, b, ok);
		fork
			u_far.send(1'b0, r[15:0], r[15:0], ok);
			begin
				// Third word must wait for room, not be lost
				repeat (30) @(posedge clk);
				chk(ack, 1'b0);
				apb(1'b0, 8'h04, 32'h0);
				chk(rdat, {16'h0, a});
			end
		join
		apb(1'b0, 8'h04, 32'h0);
		chk(rdat, {16'h0, b});
		apb(1'b0, 8'h04, 32'h0);
		chk({ok, rdat}, {1'b1, 16'h0, r[15:0]});
		u_far.send(1'b0, a, a, ok);
		apb(1'b1, 8'h00, 32'h0723);
		chk({ack, extra}, 2'b11);
		apb(1'b1, 8'h00, 32'h0620);
		apb(1'b0, 8'h0c, 32'h0);
		chk({ack, extra, rdat[4:0]}, 7'h00);
		apb(1'b1, 8'h00, 32'h0620);
		u_far.send(1'b0, b, b, ok);
		apb(1'b0, 8'h04, 32'h0);
		chk(rdat, {16'h0, b});
		for (int i = 0; i < 6; i++)
		begin
			pl = (i % 3) != 0;
			tr = (i % 3) == 2;
			r = $urandom;
			apb(1'b1, 8'h00, 32'h0);
			u_far.rinv <= r[0];
			u_far.ainv <= r[1];
			repeat (6) @(posedge clk);
			apb(1'b1, 8'h00, {21'h0, 3'b110, r[2], r[0], 1'b1, pl, tr, r[1], r[1], 1'b0});
			a = $urandom;
			b = $urandom;
			u_far.send(pl, a, b, ok);
			apb(1'b0, 8'h04, 32'h0);
			chk({ok, rdat}, {1'b1, 16'h0, expw(pl, tr, a, b)});
		end
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b0, 8'h04, 32'h0);
		chk(rdat, {16'h0, ~b});
		u_far.ainv = 1'b0;
		u_far.send(1'b0, a, a, ok);
		chk(ok, 1'b0);
		results();
	end
	initial
	begin
		#(20000 * 50);
		errors++;
		results();
	end
endmodule : test_g2h_port
